/* design/hpdma_pkg.sv */
// ==========================================================
// Constants for the DMA host port
package hpdma_pkg;
  // ========================================================
  // Register byte offsets
  localparam logic [7:0] HPDMA_OFF_HOST_CTRL = 8'h00;
  localparam logic [7:0] HPDMA_OFF_CORE_CTRL = 8'h04;
  localparam logic [7:0] HPDMA_OFF_STATUS = 8'h08;
  localparam logic [7:0] HPDMA_OFF_TX_WORD = 8'h0C;
  localparam logic [7:0] HPDMA_OFF_RX_WORD = 8'h10;
  // ========================================================
  // host_irq_control field positions
  localparam int HPDMA_BIT_RX_REQ = 0;
  localparam int HPDMA_BIT_TX_REQ = 1;
  localparam int HPDMA_BIT_INIT = 3;
  localparam int HPDMA_BIT_WS0 = 5;
  localparam int HPDMA_BIT_WS1 = 6;
  // core control field positions
  localparam int HPDMA_BIT_RX_IE = 0;
  localparam int HPDMA_BIT_TX_IE = 1;
  // ========================================================
  // Host byte addresses
  localparam logic [2:0] HPDMA_ADDR_HIGH = 3'h5;
  localparam logic [2:0] HPDMA_ADDR_MID = 3'h6;
  localparam logic [2:0] HPDMA_ADDR_LOW = 3'h7;
  // ========================================================
  // Values after reset, and the synchroniser width
  localparam logic HPDMA_RST_CORE_TX_EMPTY = 1'b1;
  localparam logic HPDMA_RST_HOST_TX_EMPTY = 1'b1;
  localparam logic HPDMA_RST_FULL = 1'b0;
  localparam logic [2:0] HPDMA_RST_CNT = 3'h7;
  localparam logic [23:0] HPDMA_RST_WORD = 24'h000000;
  localparam logic [7:0] HPDMA_RST_BYTE = 8'h00;
  localparam int HPDMA_SYNC_W = 9;
endpackage : hpdma_pkg

/* design/hpdma_sync.sv */
`timescale 1ns/1ps
// ==========================================================
// Two flip-flop synchroniser
module hpdma_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '1;
      sync_out <= '1;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule : hpdma_sync

/* design/hpdma_top.sv */
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
// Function
// [R01] Transmit exception while tx empty and enabled
// [R02] Copy tx word into receive bytes
// [R03] Copy re-empties tx word, exception again
// [R04] Receive full loads counter, asserts request
// [R05] Acknowledge drops request, byte driven out
// [R06] Byte taken: not low, step and re-request
// [R07] Low byte read clears full, copy again
// [R08] Each copy reloads counter from word size
// [R09] Host starts host-to-core with init write
// [R10] Host-to-core request right after init
// [R11] Full transmit bytes go to core word
// [R12] Host enables core receive exception
// [R13] Host avoids transmit bytes during transfer
// [R14] Host ends host-to-core by clearing bits
// [R15] Host starts core-to-host with init write
// [R16] Exception raised as soon as enabled
// [R17] Host avoids receive bytes during transfer
// [R18] Host ends core-to-host by clearing bits
// [R19] Host reads receive bytes only when full
// [R20] Host writes transmit bytes only when empty
// [R21] Host reads flag pair twice
// [R22] Host changes vector only without command
// [R23] Acknowledge release latches byte, step counter
// [R24] Synchronise acknowledge and bus to pclk
module hpdma_top
  import hpdma_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dma_acknowledge_n,
  output logic dma_request_n,
  input wire logic [7:0] host_byte_bus_in,
  output logic [7:0] host_byte_bus_out,
  output logic host_byte_bus_oe,
  output logic core_tx_irq,
  output logic core_rx_irq
);
  // ========================================================
  // Helpers
  function automatic logic [2:0] load_addr(input logic [1:0] ws);
    case (ws)
      2'h3: load_addr = HPDMA_ADDR_HIGH;
      2'h2: load_addr = HPDMA_ADDR_MID;
      default: load_addr = HPDMA_ADDR_LOW;
    endcase
  endfunction : load_addr

  function automatic logic [1:0] byte_idx(input logic [2:0] addr);
    byte_idx = 2'(addr - HPDMA_ADDR_HIGH);
  endfunction : byte_idx

  // ========================================================
  // State
  logic rx_request_sel, tx_request_sel, word_size_bit0, word_size_bit1;
  logic init_pend, core_tx_irq_en, core_rx_irq_en;
  logic core_tx_empty, core_rx_full, host_rx_full, host_tx_empty;
  logic [23:0] core_tx_word, core_rx_word;
  logic [7:0] rx_byte [0:2];
  logic [7:0] tx_byte [0:2];
  logic [2:0] cnt;
  logic req, ack_d;
  logic [7:0] bus_hold;
  logic [8:0] sync_q;
  logic ack_s;
  logic [7:0] bus_s;

  // ========================================================
  // Pin synchronisation
  hpdma_sync #(.WIDTH(HPDMA_SYNC_W)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({dma_acknowledge_n, host_byte_bus_in}),
    .sync_out(sync_q)
  );
  assign ack_s = sync_q[8]; // R24
  assign bus_s = sync_q[7:0]; // R24

  // ========================================================
  // Decode
  wire [1:0] ws = {word_size_bit1, word_size_bit0};
  wire dma_on = (ws != 2'h0);
  wire dir_d2h = dma_on & rx_request_sel & ~tx_request_sel;
  wire dir_h2d = dma_on & tx_request_sel & ~rx_request_sel;
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr_ctrl = access & pwrite & (paddr == HPDMA_OFF_HOST_CTRL);
  wire wr_cctl = access & pwrite & (paddr == HPDMA_OFF_CORE_CTRL);
  wire wr_tx = access & pwrite & (paddr == HPDMA_OFF_TX_WORD);
  wire rd_rx = access & ~pwrite & (paddr == HPDMA_OFF_RX_WORD);
  wire mapped = (paddr == HPDMA_OFF_HOST_CTRL) | (paddr == HPDMA_OFF_CORE_CTRL) |
                (paddr == HPDMA_OFF_STATUS) | (paddr == HPDMA_OFF_TX_WORD) |
                (paddr == HPDMA_OFF_RX_WORD);
  wire ack_fall = ack_d & ~ack_s;
  wire ack_rise = ~ack_d & ack_s;
  wire last = (cnt == HPDMA_ADDR_LOW);
  wire [1:0] idx = byte_idx(cnt);
  // A core write in the same cycle holds the copy off, so the pending word is overwritten and the new word is copied
  wire copy_d2h = dir_d2h & ~host_rx_full & ~core_tx_empty & ~wr_tx; // R02
  wire d2h_step = dir_d2h & ack_rise & ~last;
  wire d2h_done = dir_d2h & ack_rise & last;
  wire h2d_step = dir_h2d & ack_rise & ~last;
  wire h2d_done = dir_h2d & ack_rise & last;
  wire h2d_xfer = dir_h2d & ~host_tx_empty & ~core_rx_full; // R11
  wire [23:0] tx_assembled = {tx_byte[0], tx_byte[1], tx_byte[2]};

  wire [31:0] ctrl_rd = 32'({word_size_bit1, word_size_bit0, 1'b0, init_pend, 1'b0, tx_request_sel,
                             rx_request_sel});
  wire [31:0] stat_rd = 32'({cnt, ~dma_request_n, host_tx_empty, host_rx_full, core_tx_empty,
                             core_rx_full});
  wire [31:0] rd_mux = (paddr == HPDMA_OFF_HOST_CTRL) ? ctrl_rd :
                       (paddr == HPDMA_OFF_CORE_CTRL) ? 32'({core_tx_irq_en, core_rx_irq_en}) :
                       (paddr == HPDMA_OFF_STATUS) ? stat_rd :
                       (paddr == HPDMA_OFF_RX_WORD) ? 32'(core_rx_word) : 32'h00000000;

  assign pready = 1'b1;
  assign core_tx_irq = core_tx_empty & core_tx_irq_en; // R01 R03 R16
  assign core_rx_irq = core_rx_full & core_rx_irq_en;
  assign dma_request_n = ~req;
  assign host_byte_bus_oe = dir_d2h & ~ack_s & ~ack_d; // R05

  // ========================================================
  // APB registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h00000000 : rd_mux;
      pslverr <= ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {word_size_bit1, word_size_bit0, tx_request_sel, rx_request_sel} <= 4'h0;
      init_pend <= 1'b0;
    end else begin
      init_pend <= wr_ctrl & pwdata[HPDMA_BIT_INIT];
      if (wr_ctrl) begin
        word_size_bit1 <= pwdata[HPDMA_BIT_WS1];
        word_size_bit0 <= pwdata[HPDMA_BIT_WS0];
        tx_request_sel <= pwdata[HPDMA_BIT_TX_REQ];
        rx_request_sel <= pwdata[HPDMA_BIT_RX_REQ];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_tx_irq_en <= 1'b0;
      core_rx_irq_en <= 1'b0;
      core_tx_word <= HPDMA_RST_WORD;
    end else begin
      if (wr_cctl) begin
        core_tx_irq_en <= pwdata[HPDMA_BIT_TX_IE];
        core_rx_irq_en <= pwdata[HPDMA_BIT_RX_IE];
      end
      if (wr_tx) begin
        core_tx_word <= pwdata[23:0];
      end
    end
  end

  // ========================================================
  // Flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_tx_empty <= HPDMA_RST_CORE_TX_EMPTY;
      host_rx_full <= HPDMA_RST_FULL;
    end else begin
      if (copy_d2h) begin
        core_tx_empty <= 1'b1; // R02 R03
      end else if (wr_tx) begin
        core_tx_empty <= 1'b0; // R01
      end
      if (init_pend) begin
        host_rx_full <= 1'b0;
      end else if (copy_d2h) begin
        host_rx_full <= 1'b1; // R02 R07
      end else if (d2h_done) begin
        host_rx_full <= 1'b0; // R07
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_tx_empty <= HPDMA_RST_HOST_TX_EMPTY;
      core_rx_full <= HPDMA_RST_FULL;
      core_rx_word <= HPDMA_RST_WORD;
    end else begin
      if (init_pend || h2d_xfer) begin
        host_tx_empty <= 1'b1; // R10 R11
      end else if (h2d_done) begin
        host_tx_empty <= 1'b0;
      end
      if (h2d_xfer) begin
        core_rx_full <= 1'b1; // R11
        core_rx_word <= tx_assembled; // R11
      end else if (rd_rx) begin
        core_rx_full <= 1'b0;
      end
    end
  end

  // ========================================================
  // Byte counter and request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= HPDMA_RST_CNT;
    end else if (init_pend || copy_d2h || h2d_done) begin
      cnt <= load_addr(ws); // R04 R08
    end else if (d2h_step || h2d_step) begin
      cnt <= 3'(cnt + 3'h1); // R06 R23
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req <= 1'b0;
      ack_d <= 1'b1;
    end else begin
      ack_d <= ack_s;
      if (!dma_on) begin
        req <= 1'b0;
      end else if (init_pend) begin
        req <= dir_h2d; // R10
      end else if (ack_fall) begin
        req <= 1'b0; // R05
      end else if (copy_d2h || d2h_step || h2d_step || h2d_xfer) begin
        req <= 1'b1; // R04 R06 R23
      end
    end
  end

  // ========================================================
  // Byte registers
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_bytes
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rx_byte[gi] <= HPDMA_RST_BYTE;
          tx_byte[gi] <= HPDMA_RST_BYTE;
        end else begin
          if (copy_d2h) begin
            rx_byte[gi] <= core_tx_word[23-8*gi -: 8]; // R02
          end
          if (dir_h2d && ack_rise && idx == 2'(gi)) begin
            tx_byte[gi] <= bus_hold; // R23
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_hold <= HPDMA_RST_BYTE;
      host_byte_bus_out <= HPDMA_RST_BYTE;
    end else begin
      if (!ack_s) begin
        bus_hold <= bus_s; // R24
      end
      if (dir_d2h && ack_fall) begin
        host_byte_bus_out <= rx_byte[idx]; // R05
      end
    end
  end

  // ========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_tx_write_clear: assert property (wr_tx |=> !core_tx_empty) // R01
    else $error("tx word write did not clear empty flag");
  chk_copy_flags: assert property (copy_d2h |=> host_rx_full && core_tx_empty &&
    {rx_byte[0], rx_byte[1], rx_byte[2]} == $past(core_tx_word)) // R02
    else $error("copy to receive bytes wrong");
  chk_second_exc: assert property (copy_d2h && core_tx_irq_en && !wr_cctl |=> core_tx_irq) // R03
    else $error("no second transmit exception");
  chk_full_request: assert property (copy_d2h && !ack_fall |=> !dma_request_n) // R04
    else $error("request not raised on receive full");
  chk_ack_drops: assert property (ack_fall && dma_on && !init_pend |=> dma_request_n) // R05
    else $error("request held during acknowledge");
  chk_step_rereq: assert property (d2h_step && !init_pend |=> !dma_request_n &&
    cnt == 3'($past(cnt) + 3'h1)) // R06
    else $error("counter step or request missing");
  chk_low_clears: assert property (d2h_done && !init_pend |=> !host_rx_full) // R07
    else $error("low byte read left full set");
  chk_cnt_reload: assert property (copy_d2h |=> cnt == load_addr($past(ws))) // R08
    else $error("counter not reloaded on copy");
  chk_init_req: assert property (init_pend && dir_h2d |=> !dma_request_n ##1 host_tx_empty) // R10
    else $error("no request after init");
  chk_h2d_word: assert property (h2d_xfer |=> core_rx_full && core_rx_word == $past(tx_assembled)) // R11
    else $error("transmit bytes not moved to core word");
  chk_enable_exc: assert property (wr_cctl && pwdata[HPDMA_BIT_TX_IE] && core_tx_empty |=> core_tx_irq) // R16
    else $error("exception not raised on enable");
  chk_h2d_latch: assert property (h2d_step && !init_pend |=> !dma_request_n &&
    tx_byte[$past(idx)] == $past(bus_hold)) // R23
    else $error("host byte not latched");

  cov_d2h_copy: cover property (copy_d2h ##[1:200] d2h_done);
  cov_h2d_word: cover property (h2d_done ##[1:20] h2d_xfer);
  cov_second_copy: cover property (d2h_done ##[1:4] copy_d2h);
endmodule : hpdma_top

/* verification/hpdma_dma_model.sv */
`timescale 1ns/1ps
// ==========================================================
// External DMA controller: serves one byte per request
module hpdma_dma_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic dir_to_core,
  input wire logic [23:0] src_word,
  input wire logic dma_request_n,
  input wire logic [7:0] bus_wire,
  output logic dma_acknowledge_n,
  output logic [7:0] bus_drive,
  output logic xfer_stb,
  output logic [7:0] xfer_byte
);
  int idx;
  logic slow;
  initial begin
    dma_acknowledge_n = 1'b1;
    bus_drive = 8'h00;
    xfer_stb = 1'b0;
    xfer_byte = 8'h00;
    idx = 0;
    slow = 1'b0;
    forever begin
      @(posedge pclk);
      xfer_stb <= 1'b0;
      // A new channel run starts from the high byte of the source word
      if (!go) idx = 0;
      if (presetn && go && !dma_request_n) begin
        // Alternate prompt and slow answers
        repeat (slow ? 5 : 0) @(posedge pclk);
        slow = !slow;
        if (dir_to_core) bus_drive <= src_word[8*(2-idx) +: 8];
        dma_acknowledge_n <= 1'b0;
        repeat (6) @(posedge pclk);
        if (!dir_to_core) begin
          xfer_byte <= bus_wire;
          xfer_stb <= 1'b1;
        end
        dma_acknowledge_n <= 1'b1;
        idx = (idx == 2) ? 0 : idx + 1;
        @(posedge pclk);
        xfer_stb <= 1'b0;
        repeat (2) @(posedge pclk);
        // Released bus no longer shows the last byte
        bus_drive <= ~bus_wire;
        @(posedge pclk);
      end
    end
  end
endmodule : hpdma_dma_model

/* verification/tb_top.sv */
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the DMA host port
module tb_top;
  import hpdma_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic dma_acknowledge_n, dma_request_n, oe, core_tx_irq, core_rx_irq;
  logic [7:0] bus_out, bus_drive, bus_wire, xfer_byte;
  logic go, dir_to_core, xfer_stb;
  logic [23:0] src_word, w;
  logic [31:0] seed;
  logic [32:0] eq[$], mq[$];
  logic [7:0] bq[$];
  int fails, checked, n;
  assign bus_wire = oe ? bus_out : bus_drive;
  hpdma_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dma_acknowledge_n(dma_acknowledge_n), .dma_request_n(dma_request_n), .host_byte_bus_in(bus_wire),
    .host_byte_bus_out(bus_out), .host_byte_bus_oe(oe), .core_tx_irq(core_tx_irq), .core_rx_irq(core_rx_irq));
  hpdma_dma_model i_dma (.pclk(pclk), .presetn(presetn), .go(go), .dir_to_core(dir_to_core),
    .src_word(src_word), .dma_request_n(dma_request_n), .bus_wire(bus_wire),
    .dma_acknowledge_n(dma_acknowledge_n), .bus_drive(bus_drive), .xfer_stb(xfer_stb), .xfer_byte(xfer_byte));
  // ========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic report_and_stop();
    if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      fails++;
      report_and_stop();
    end
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
    eq.push_back(e);
    mq.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic push_word(input logic [23:0] x);
    bq.push_back(x[23:16]);
    bq.push_back(x[15:8]);
    bq.push_back(x[7:0]);
  endtask : push_word
  task automatic drain();
    n = 0;
    while (bq.size() != 0 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 3000) begin
      fails++;
      report_and_stop();
    end
  endtask : drain
  // ========================================================
  // Monitors
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) check({pslverr, prdata} & mq.pop_front(), eq.pop_front());
    if (xfer_stb) check({25'h0, xfer_byte}, {25'h0, bq.pop_front()});
  end
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // ========================================================
  // Main sequence
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, go, dir_to_core} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    src_word = 24'h0;
    seed = 32'hBA3DBB67;
    fails = 0;
    checked = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(HPDMA_OFF_STATUS, 33'h0EA, 33'h0FF);
    rd(8'h40, 33'h100000000, 33'h1FFFFFFFF);
    // Core to host, 24-bit words
    apb(1'b1, HPDMA_OFF_HOST_CTRL, 32'h69);
    apb(1'b1, HPDMA_OFF_CORE_CTRL, 32'h2);
    repeat (2) @(posedge pclk);
    check({32'h0, core_tx_irq}, 33'h1);
    seed = xs(seed);
    w = seed[23:0];
    push_word(w);
    apb(1'b1, HPDMA_OFF_TX_WORD, {8'h0, w});
    repeat (2) @(posedge pclk);
    check({32'h0, core_tx_irq}, 33'h1);
    check({32'h0, dma_request_n}, 33'h0);
    rd(HPDMA_OFF_STATUS, 33'h0BE, 33'h0FF);
    seed = xs(seed);
    w = seed[23:0];
    push_word(w);
    apb(1'b1, HPDMA_OFF_TX_WORD, {8'h0, w});
    check({32'h0, core_tx_irq}, 33'h0);
    go <= 1'b1;
    drain();
    repeat (4) @(posedge pclk);
    check({32'h0, core_tx_irq}, 33'h1);
    go <= 1'b0;
    // Core to host, 16-bit words: the high byte is never presented
    apb(1'b1, HPDMA_OFF_HOST_CTRL, 32'h49);
    seed = xs(seed);
    w = seed[23:0];
    bq.push_back(w[15:8]);
    bq.push_back(w[7:0]);
    apb(1'b1, HPDMA_OFF_TX_WORD, {8'h0, w});
    rd(HPDMA_OFF_STATUS, 33'h0DE, 33'h0FF);
    rd(HPDMA_OFF_STATUS, 33'h0DE, 33'h0FF);
    go <= 1'b1;
    drain();
    repeat (4) @(posedge pclk);
    go <= 1'b0;
    apb(1'b1, HPDMA_OFF_HOST_CTRL, 32'h0);
    apb(1'b1, HPDMA_OFF_CORE_CTRL, 32'h0);
    // Host to core, 24-bit words
    dir_to_core <= 1'b1;
    seed = xs(seed);
    src_word <= seed[23:0];
    apb(1'b1, HPDMA_OFF_CORE_CTRL, 32'h1);
    apb(1'b1, HPDMA_OFF_HOST_CTRL, 32'h6A);
    repeat (2) @(posedge pclk);
    check({32'h0, dma_request_n}, 33'h0);
    go <= 1'b1;
    n = 0;
    while (core_rx_irq !== 1'b1 && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 1000) begin
      fails++;
      report_and_stop();
    end
    go <= 1'b0;
    rd(HPDMA_OFF_RX_WORD, {9'h0, src_word}, 33'h0FFFFFF);
    rd(HPDMA_OFF_STATUS, 33'h0, 33'h001);
    check({32'h0, core_rx_irq}, 33'h0);
    repeat (20) @(posedge pclk);
    apb(1'b1, HPDMA_OFF_HOST_CTRL, 32'h0);
    report_and_stop();
  end
endmodule : tb_top
